// *** sdf_pkg.sv ***
// Package of constants and types for the shear dwell and feed tracking block.
package sdf_pkg;

  // ****************************************************************
  // Clock and timing
  // ****************************************************************
  localparam int unsigned CLK_HZ = 20_000_000;
  localparam int unsigned TICK_US = 1000;
  localparam int unsigned TICK_CYC = CLK_HZ / 1_000_000 * TICK_US;
  localparam logic [13:0] DWELL_DN_MIN = 14'h0001;
  localparam logic [13:0] DWELL_MAX = 14'h270F;
  localparam logic [13:0] DWELL_UP_MIN = 14'h0000;
  localparam logic [13:0] DWELL_RST = 14'h007D;

  // ****************************************************************
  // APB register map
  // ****************************************************************
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_DWELL_DN = 8'h04;
  localparam logic [7:0] REG_DWELL_UP = 8'h08;
  localparam logic [7:0] REG_LINE_RES = 8'h0C;
  localparam logic [7:0] REG_MOTOR_RES = 8'h10;
  localparam logic [7:0] REG_GAIN = 8'h14;
  localparam logic [7:0] REG_ACCEL = 8'h18;
  localparam logic [7:0] REG_VMAX = 8'h1C;
  localparam logic [7:0] REG_VJOG = 8'h20;
  localparam logic [7:0] REG_TRIM = 8'h24;
  localparam logic [7:0] REG_STATUS = 8'h28;
  localparam logic [7:0] REG_LENGTH = 8'h2C;
  localparam logic [7:0] REG_MPOS = 8'h30;
  localparam logic [7:0] REG_CMD = 8'h34;

  // Control register bit positions.
  localparam int unsigned CTRL_TWO_ENC = 0;
  localparam int unsigned CTRL_ASSIST = 1;
  localparam int unsigned CTRL_AUTO = 2;
  localparam int unsigned CTRL_JOG = 3;
  localparam int unsigned CTRL_FIRE = 4;
  localparam int unsigned CTRL_TRIM_OK = 5;

  // Reset values and the trim fraction width.
  localparam logic [15:0] TRIM_UNITY = 16'h4000;
  localparam int unsigned TRIM_FRAC = 14;
  localparam logic [15:0] RES_RST = 16'h0001;
  localparam logic [15:0] GAIN_RST = 16'h0002;
  localparam logic [15:0] ACCEL_RST = 16'h0001;
  localparam logic [15:0] VEL_RST = 16'h0000;

  // Shear sequence states.
  typedef enum logic [1:0] {SDF_IDLE, SDF_DOWN, SDF_UP} sdf_shear_e;

endpackage

// *** sdf_press.sv ***
// Model of the press switch, sheet switch and both encoders.
`timescale 1ns/1ns
`default_nettype none
module sdf_press
  import sdf_pkg::*;
(
  input wire logic pclk, // Clock.
  input wire logic shear_down_out, // Shear down from the block.
  input wire logic [15:0] close_at, // Switch delay, 0 means never.
  output logic shear_done_pin, // Complete switch.
  output logic sheet_pin, // Material present.
  output logic enc1_a, // Encoder one A.
  output logic enc1_b, // Encoder one B.
  output logic enc2_a, // Encoder two A.
  output logic enc2_b // Encoder two B.
);
  logic dn_q;
  logic [1:0] ph [2];
  int t;
  // Idle levels, so nothing floats at time zero.
  initial
  begin
    {dn_q, shear_done_pin, sheet_pin, enc1_a, enc1_b, enc2_a, enc2_b} = '0;
    ph[0] = 2'h0;
    ph[1] = 2'h0;
    t = 0;
  end
  // The switch makes a set time into the stroke and opens 3000 cycles on.
  always @(posedge pclk)
  begin
    dn_q <= shear_down_out;
    if (shear_down_out && !dn_q)
      t <= 1;
    else if (t != 0)
      t <= t + 1;
    shear_done_pin <= close_at != 0 && t >= close_at && t < close_at + 3000;
  end
  // One Gray step every four cycles, so the synchronisers see each level.
  task turn(input logic two, input int n, input logic rev);
    int i;
    for (i = 0; i < 4 * n; i++)
    begin
      @(posedge pclk);
      ph[two] = rev ? ph[two] - 2'd1 : ph[two] + 2'd1;
      if (two)
      begin
        enc2_a <= ph[1][1] ^ ph[1][0];
        enc2_b <= ph[1][1];
      end
      else
      begin
        enc1_a <= ph[0][1] ^ ph[0][0];
        enc1_b <= ph[0][1];
      end
      repeat (3) @(posedge pclk);
    end
  endtask
  // Called only once the line wheel has turned.
  task set_sheet(input logic v);
    sheet_pin <= v;
  endtask
endmodule
`default_nettype wire

// *** sdf_props.sv ***
// Port-level checker for the shear dwell and feed tracking block.
`timescale 1ns/1ns
`default_nettype none
module sdf_props
  import sdf_pkg::*;
(
  input wire logic pclk, // Clock.
  input wire logic presetn, // Reset, active low.
  input wire logic psel, // Select.
  input wire logic penable, // Enable.
  input wire logic pwrite, // Write.
  input wire logic [7:0] paddr, // Address.
  input wire logic [31:0] pwdata, // Write data.
  input wire logic [31:0] prdata, // Read data.
  input wire logic pready, // Ready.
  input wire logic pslverr, // Error.
  input wire logic shear_done_pin, // Complete switch.
  input wire logic sheet_pin, // Material present.
  input wire logic enc1_a, // Encoder one A.
  input wire logic enc1_b, // Encoder one B.
  input wire logic enc2_a, // Encoder two A.
  input wire logic enc2_b, // Encoder two B.
  input wire logic shear_down_out, // Shear down.
  input wire logic shear_up_out, // Up dwell.
  input wire logic press_assist_output, // Assist.
  input wire logic [31:0] motor_cmd // Velocity command.
);
  // ****************************************************************
  // Properties
  // ****************************************************************
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence access_start;
    psel && penable && !pready;
  endsequence
  sequence switch_made;
    shear_done_pin && shear_down_out;
  endsequence
  // Sync flops plus output register give the switch a few edges.
  ready_time_a: assert property (access_start |=> pready)
    else $error("pready late");
  ready_pulse_a: assert property (pready |=> !pready)
    else $error("pready held");
  err_ready_a: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  err_rdata_a: assert property (pready && pslverr && !pwrite |->
    prdata == 32'h0000_0000) else $error("error read not zero");
  done_drop_a: assert property (switch_made |-> ##[1:4] !shear_down_out)
    else $error("down not ended by switch");
  up_start_a: assert property ($rose(shear_up_out) |-> !shear_down_out &&
    ($past(shear_down_out) || $past(shear_down_out, 2)))
    else $error("up dwell not after down");
  dwell_excl_a: assert property (!(shear_down_out && shear_up_out))
    else $error("down and up together");
  assist_follow_a: assert property ($fell(press_assist_output) &&
    !shear_down_out |-> !shear_up_out) else $error("up dwell after assist");
  cmd_hold_a: assert property (!sheet_pin && $changed(motor_cmd) |=>
    ($stable(motor_cmd) || sheet_pin || $past(sheet_pin, 3))[*8])
    else $error("command changed off tick");
  rst_idle_a: assert property ($rose(presetn) |-> !shear_down_out &&
    !shear_up_out && motor_cmd == 32'h0000_0000)
    else $error("outputs not idle after reset");
endmodule
bind sdf_top sdf_props i_sdf_props (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .shear_done_pin(shear_done_pin), .sheet_pin(sheet_pin), .enc1_a(enc1_a),
  .enc1_b(enc1_b), .enc2_a(enc2_a), .enc2_b(enc2_b),
  .shear_down_out(shear_down_out), .shear_up_out(shear_up_out),
  .press_assist_output(press_assist_output), .motor_cmd(motor_cmd));
`default_nettype wire

// *** sdf_quad.sv ***
// Quadrature decoder counting every edge of both channels.
`timescale 1ns/1ns
`default_nettype none
module sdf_quad
  import sdf_pkg::*;
(
  input wire logic pclk, // System clock.
  input wire logic presetn, // Asynchronous reset, active low.
  input wire logic ch_a, // Channel A, already synchronised.
  input wire logic ch_b, // Channel B, already synchronised.
  output logic [31:0] count // Signed edge count.
);

  // ****************************************************************
  // Edge decode
  // ****************************************************************
  logic [1:0] prev_ff;
  logic [1:0] nxt_prev;
  logic [31:0] count_ff;
  logic [31:0] nxt_count;

  // Each valid transition of the AB pair is one pulse, four per cycle.
  always_comb
  begin
    nxt_prev = {ch_a, ch_b};
    nxt_count = count_ff;
    unique case ({prev_ff, ch_a, ch_b})
      4'b0001, 4'b0111, 4'b1110, 4'b1000: nxt_count = count_ff + 32'h0000_0001;
      4'b0010, 4'b1011, 4'b1101, 4'b0100: nxt_count = count_ff - 32'h0000_0001;
      default: nxt_count = count_ff;
    endcase
  end

  // Registers only; a double-step transition is dropped as noise.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prev_ff <= 2'h0;
      count_ff <= 32'h0000_0000;
    end
    else
    begin
      prev_ff <= nxt_prev;
      count_ff <= nxt_count;
    end
  end

  assign count = count_ff;

endmodule
`default_nettype wire

// *** sdf_tick.sv ***
// Millisecond tick divider.
`timescale 1ns/1ns
`default_nettype none
module sdf_tick
  import sdf_pkg::*;
(
  input wire logic pclk, // System clock.
  input wire logic presetn, // Asynchronous reset, active low.
  output logic tick // One-cycle pulse every millisecond.
);

  // ****************************************************************
  // Divider
  // ****************************************************************
  localparam logic [15:0] TICK_LAST = 16'(TICK_CYC - 1);
  logic [15:0] cnt_ff;
  logic [15:0] nxt_cnt;
  logic tick_ff;
  logic nxt_tick;

  // Count up one millisecond of clock cycles.
  always_comb
  begin
    nxt_tick = (cnt_ff == TICK_LAST);
    nxt_cnt = nxt_tick ? 16'h0000 : cnt_ff + 16'h0001;
  end

  // Registers only.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cnt_ff <= 16'h0000;
      tick_ff <= 1'b0;
    end
    else
    begin
      cnt_ff <= nxt_cnt;
      tick_ff <= nxt_tick;
    end
  end

  assign tick = tick_ff;

endmodule
`default_nettype wire

// *** sdf_top.sv ***
// Shear dwell sequencer and feed tracking with APB registers.
// Function
// - Shear-down output held for programmed 0.001 to 9.999 s after firing.
// - Without assist output, a separate up dwell of 0 to 9.999 s.
// - Shear-complete switch during down dwell ends it and drops output at once.
// - Up dwell always runs full time, ignoring shear-complete switch.
// - Single-encoder mode tracks material only from encoder input one.
// - Two-encoder mode takes the line encoder from encoder input two.
// - Two-encoder mode switches tracking to line encoder on material present.
// - Four pulses counted per rated encoder cycle by quadrature decoding.
// - Line length is line pulse count times programmed line resolution.
// - Motor travel is motor count times programmed motor resolution.
// - Position error corrected at a rate scaled by the loop gain.
// - Forward velocity ramp limited to programmed acceleration; the line-tracking error term is added unlimited.
// - Automatic operation commands the programmed maximum velocity.
// - Jogging commands the programmed jog velocity.
// - Length trim scale updated only on operator confirmation.
`timescale 1ns/1ns
`default_nettype none
module sdf_top
  import sdf_pkg::*;
(
  input wire logic pclk, // System clock, 20 MHz.
  input wire logic presetn, // Asynchronous reset, active low.
  input wire logic psel, // APB select.
  input wire logic penable, // APB enable.
  input wire logic pwrite, // APB write.
  input wire logic [7:0] paddr, // APB byte address.
  input wire logic [31:0] pwdata, // APB write data.
  output logic [31:0] prdata, // APB read data.
  output logic pready, // APB ready.
  output logic pslverr, // APB error on unmapped address.
  input wire logic shear_done_pin, // Shear-complete switch, high closed.
  input wire logic sheet_pin, // Material-present switch, high active.
  input wire logic enc1_a, // Encoder input one channel A.
  input wire logic enc1_b, // Encoder input one channel B.
  input wire logic enc2_a, // Encoder input two channel A.
  input wire logic enc2_b, // Encoder input two channel B.
  output logic shear_down_out, // Shear-down output, high active.
  output logic shear_up_out, // Up dwell in progress, high active.
  output logic press_assist_output, // Assist output, follows shear-down.
  output logic [31:0] motor_cmd // Signed velocity command to the drive.
);

  // ****************************************************************
  // Input synchronisers
  // ****************************************************************
  logic [5:0] sync1_ff;
  logic [5:0] sync2_ff;

  // Two flops per pin; only the second stage feeds logic.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      sync1_ff <= 6'h00;
      sync2_ff <= 6'h00;
    end
    else
    begin
      sync1_ff <= {shear_done_pin, sheet_pin, enc1_a, enc1_b, enc2_a, enc2_b};
      sync2_ff <= sync1_ff;
    end
  end

  logic done_s;
  logic sheet_s;
  assign done_s = sync2_ff[5];
  assign sheet_s = sync2_ff[4];

  // ****************************************************************
  // Encoders and tick
  // ****************************************************************
  logic [31:0] mcount;
  logic [31:0] lcount;
  logic tick;

  sdf_quad u_enc1 (.pclk(pclk), .presetn(presetn), .ch_a(sync2_ff[3]),
    .ch_b(sync2_ff[2]), .count(mcount));
  sdf_quad u_enc2 (.pclk(pclk), .presetn(presetn), .ch_a(sync2_ff[1]),
    .ch_b(sync2_ff[0]), .count(lcount));
  sdf_tick u_tick (.pclk(pclk), .presetn(presetn), .tick(tick));

  // ****************************************************************
  // Registers
  // ****************************************************************
  logic [5:0] ctrl_ff, nxt_ctrl;
  logic [13:0] dn_ff, nxt_dn, up_ff, nxt_up;
  logic [15:0] lres_ff, nxt_lres, mres_ff, nxt_mres, gain_ff, nxt_gain;
  logic [15:0] acc_ff, nxt_acc, vmax_ff, nxt_vmax, vjog_ff, nxt_vjog;
  logic [15:0] trim_pend_ff, nxt_trim_pend, trim_ff, nxt_trim;
  logic [31:0] prdata_ff, nxt_prdata;
  logic pslverr_ff, nxt_pslverr, pready_ff, nxt_pready;
  logic fire_pulse;
  logic [31:0] length_val, mpos_val;
  logic [1:0] state_ff;

  // Clamp a dwell write into its legal range.
  function automatic logic [13:0] clamp_dwell(input logic [31:0] v,
                                              input logic [13:0] lo);
    if (v > {18'h0_0000, DWELL_MAX})
      clamp_dwell = DWELL_MAX;
    else if (v[13:0] < lo)
      clamp_dwell = lo;
    else
      clamp_dwell = v[13:0];
  endfunction

  // APB slave: one wait state, write and read act in the access phase.
  always_comb
  begin
    nxt_ctrl = ctrl_ff;
    nxt_ctrl[CTRL_FIRE] = 1'b0;
    nxt_ctrl[CTRL_TRIM_OK] = 1'b0;
    nxt_dn = dn_ff;
    nxt_up = up_ff;
    nxt_lres = lres_ff;
    nxt_mres = mres_ff;
    nxt_gain = gain_ff;
    nxt_acc = acc_ff;
    nxt_vmax = vmax_ff;
    nxt_vjog = vjog_ff;
    nxt_trim_pend = trim_pend_ff;
    nxt_trim = trim_ff;
    nxt_prdata = prdata_ff;
    nxt_pslverr = 1'b0;
    nxt_pready = psel && penable && !pready_ff;
    if (psel && penable && !pready_ff)
    begin
      nxt_pslverr = 1'b0;
      nxt_prdata = 32'h0000_0000;
      unique case (paddr)
        REG_CTRL:
        begin
          if (pwrite) nxt_ctrl = pwdata[5:0];
          nxt_prdata = {26'h000_0000, ctrl_ff};
        end
        REG_DWELL_DN:
        begin
          if (pwrite) nxt_dn = clamp_dwell(pwdata, DWELL_DN_MIN);
          nxt_prdata = {18'h0_0000, dn_ff};
        end
        REG_DWELL_UP:
        begin
          if (pwrite) nxt_up = clamp_dwell(pwdata, DWELL_UP_MIN);
          nxt_prdata = {18'h0_0000, up_ff};
        end
        REG_LINE_RES:
        begin
          if (pwrite) nxt_lres = pwdata[15:0];
          nxt_prdata = {16'h0000, lres_ff};
        end
        REG_MOTOR_RES:
        begin
          if (pwrite) nxt_mres = pwdata[15:0];
          nxt_prdata = {16'h0000, mres_ff};
        end
        REG_GAIN:
        begin
          if (pwrite) nxt_gain = pwdata[15:0];
          nxt_prdata = {16'h0000, gain_ff};
        end
        REG_ACCEL:
        begin
          if (pwrite) nxt_acc = pwdata[15:0];
          nxt_prdata = {16'h0000, acc_ff};
        end
        REG_VMAX:
        begin
          if (pwrite) nxt_vmax = pwdata[15:0];
          nxt_prdata = {16'h0000, vmax_ff};
        end
        REG_VJOG:
        begin
          if (pwrite) nxt_vjog = pwdata[15:0];
          nxt_prdata = {16'h0000, vjog_ff};
        end
        REG_TRIM:
        begin
          if (pwrite) nxt_trim_pend = pwdata[15:0];
          nxt_prdata = {trim_pend_ff, trim_ff};
        end
        REG_STATUS: nxt_prdata = {28'h000_0000, sheet_s, done_s, state_ff};
        REG_LENGTH: nxt_prdata = length_val;
        REG_MPOS: nxt_prdata = mpos_val;
        REG_CMD: nxt_prdata = motor_cmd;
        default: nxt_pslverr = 1'b1;
      endcase
      if (pwrite)
        nxt_prdata = prdata_ff;
    end
    // A proposed trim only becomes active on the confirm strobe.
    if (ctrl_ff[CTRL_TRIM_OK])
      nxt_trim = trim_pend_ff;
  end

  assign fire_pulse = ctrl_ff[CTRL_FIRE];

  // Register file flops.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctrl_ff <= 6'h00;
      dn_ff <= DWELL_RST;
      up_ff <= DWELL_RST;
      lres_ff <= RES_RST;
      mres_ff <= RES_RST;
      gain_ff <= GAIN_RST;
      acc_ff <= ACCEL_RST;
      vmax_ff <= VEL_RST;
      vjog_ff <= VEL_RST;
      trim_pend_ff <= TRIM_UNITY;
      trim_ff <= TRIM_UNITY;
      prdata_ff <= 32'h0000_0000;
      pslverr_ff <= 1'b0;
      pready_ff <= 1'b0;
    end
    else
    begin
      ctrl_ff <= nxt_ctrl;
      dn_ff <= nxt_dn;
      up_ff <= nxt_up;
      lres_ff <= nxt_lres;
      mres_ff <= nxt_mres;
      gain_ff <= nxt_gain;
      acc_ff <= nxt_acc;
      vmax_ff <= nxt_vmax;
      vjog_ff <= nxt_vjog;
      trim_pend_ff <= nxt_trim_pend;
      trim_ff <= nxt_trim;
      prdata_ff <= nxt_prdata;
      pslverr_ff <= nxt_pslverr;
      pready_ff <= nxt_pready;
    end
  end

  assign prdata = prdata_ff;
  assign pready = pready_ff;
  assign pslverr = pslverr_ff;

  // ****************************************************************
  // Shear dwell sequencer
  // ****************************************************************
  sdf_shear_e st_ff, nxt_st;
  logic [13:0] ms_ff, nxt_ms;
  logic down_ff, nxt_down, upo_ff, nxt_upo, assist_ff, nxt_assist;
  assign state_ff = st_ff;

  // Millisecond dwell counter; the up dwell is skipped when assist is used.
  always_comb
  begin
    nxt_st = st_ff;
    nxt_ms = ms_ff;
    unique case (st_ff)
      SDF_IDLE:
        if (fire_pulse)
        begin
          nxt_st = SDF_DOWN;
          nxt_ms = 14'h0000;
        end
      SDF_DOWN:
        if (done_s || (tick && ms_ff + 14'h0001 >= dn_ff))
        begin
          // The up timer starts at the instant the output drops.
          nxt_ms = 14'h0000;
          nxt_st = (ctrl_ff[CTRL_ASSIST] || up_ff == 14'h0000) ?
                   SDF_IDLE : SDF_UP;
        end
        else if (tick)
          nxt_ms = ms_ff + 14'h0001;
      SDF_UP:
        // The complete switch has no effect here.
        if (tick && ms_ff + 14'h0001 >= up_ff)
          nxt_st = SDF_IDLE;
        else if (tick)
          nxt_ms = ms_ff + 14'h0001;
    endcase
    nxt_down = (nxt_st == SDF_DOWN);
    nxt_upo = (nxt_st == SDF_UP);
    // Registered so the assist pin never glitches on a control write.
    nxt_assist = nxt_down && nxt_ctrl[CTRL_ASSIST];
  end

  // Sequencer flops.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      st_ff <= SDF_IDLE;
      ms_ff <= 14'h0000;
      down_ff <= 1'b0;
      assist_ff <= 1'b0;
      upo_ff <= 1'b0;
    end
    else
    begin
      st_ff <= nxt_st;
      ms_ff <= nxt_ms;
      down_ff <= nxt_down;
      upo_ff <= nxt_upo;
      assist_ff <= nxt_assist;
    end
  end

  assign shear_down_out = down_ff;
  assign shear_up_out = upo_ff;
  assign press_assist_output = assist_ff;

  // ****************************************************************
  // Tracking and motor command
  // ****************************************************************
  logic use_line;
  logic [31:0] travel, velo_ff, nxt_velo, cmd_ff, nxt_cmd, target, err;
  logic [47:0] trimmed;

  // Line encoder count is used for tracking only once material is present under it.
  assign use_line = ctrl_ff[CTRL_TWO_ENC] && sheet_s;
  assign length_val = 32'(lcount * {16'h0000, lres_ff});
  assign mpos_val = 32'(mcount * {16'h0000, mres_ff});
  assign travel = use_line ? length_val : mpos_val;
  assign trimmed = 48'(travel) * {32'h0000_0000, trim_ff};

  // Ramp toward the mode speed; in line tracking, add gain-scaled position error.
  always_comb
  begin
    target = 32'h0000_0000;
    if (ctrl_ff[CTRL_JOG])
      target = {16'h0000, vjog_ff};
    else if (ctrl_ff[CTRL_AUTO])
      target = {16'h0000, vmax_ff};
    nxt_velo = velo_ff;
    if (tick)
    begin
      if (target > velo_ff + {16'h0000, acc_ff})
        nxt_velo = velo_ff + {16'h0000, acc_ff};
      else if (velo_ff > target + {16'h0000, acc_ff})
        nxt_velo = velo_ff - {16'h0000, acc_ff};
      else
        nxt_velo = target;
    end
    err = 32'(trimmed >> TRIM_FRAC) - mpos_val;
    if (!use_line)
      nxt_cmd = velo_ff;
    else
      nxt_cmd = velo_ff + 32'($signed(err) * $signed({16'h0000, gain_ff}));
  end

  // Motion flops.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      velo_ff <= 32'h0000_0000;
      cmd_ff <= 32'h0000_0000;
    end
    else
    begin
      velo_ff <= nxt_velo;
      cmd_ff <= nxt_cmd;
    end
  end

  assign motor_cmd = cmd_ff;

endmodule
`default_nettype wire

// *** sdf_top_tb.sv ***
// Self-checking testbench for the shear dwell and feed tracking block.
`timescale 1ns/1ns
`default_nettype none
module sdf_top_tb
  import sdf_pkg::*;
;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, ev;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, motor_cmd, rv, pcmd;
  logic shear_done_pin, sheet_pin, enc1_a, enc1_b, enc2_a, enc2_b;
  logic shear_down_out, shear_up_out, press_assist_output;
  logic [15:0] close_at;
  int fail_count, checks, seed, acc, ld, lu, n, m, p, k;
  sdf_top i_sdf_top (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .shear_done_pin(shear_done_pin), .sheet_pin(sheet_pin), .enc1_a(enc1_a),
    .enc1_b(enc1_b), .enc2_a(enc2_a), .enc2_b(enc2_b),
    .shear_down_out(shear_down_out), .shear_up_out(shear_up_out),
    .press_assist_output(press_assist_output), .motor_cmd(motor_cmd));
  sdf_press i_sdf_press (.pclk(pclk), .shear_down_out(shear_down_out),
    .close_at(close_at), .shear_done_pin(shear_done_pin),
    .sheet_pin(sheet_pin), .enc1_a(enc1_a), .enc1_b(enc1_b),
    .enc2_a(enc2_a), .enc2_b(enc2_b));
  // ****************************************************************
  // Clock, checks and bus tasks
  // ****************************************************************
  initial
  begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end
  task summarize;
    $display("checks %0d fail_count %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task chk(input logic [31:0] g, input logic [31:0] e, input string s);
    checks++;
    if (g !== e)
    begin
      fail_count++;
      $display("FAIL %0t %s got %h exp %h", $time, s, g, e);
    end
  endtask
  // Direction sign is the wiring's business, so only magnitude is compared.
  function automatic logic [31:0] absv(input logic [31:0] v);
    return v[31] ? -v : v;
  endfunction
  // One transfer; an idle cycle after it keeps two calls apart.
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do
    begin
      @(posedge pclk);
      k++;
    end
    while (pready !== 1'b1 && k < 16);
    rv = prdata;
    ev = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1)
    begin
      fail_count++;
      summarize();
    end
    @(posedge pclk);
  endtask
  task rd(input logic [7:0] a, input logic [31:0] e, input string s);
    apb(1'b0, a, 32'h0000_0000);
    chk(rv, e, s);
  endtask
  // Fires one stroke and measures the down and up dwell lengths.
  task shot(input int dn, input int up, input int cw, input int ca);
    close_at <= 16'(ca);
    apb(1'b1, REG_DWELL_DN, 32'(dn));
    apb(1'b1, REG_DWELL_UP, 32'(up));
    apb(1'b1, REG_CTRL, 32'(cw) | 32'h0000_0010);
    {k, ld, lu} = '0;
    while (shear_down_out !== 1'b1 && k < 200)
    begin
      @(posedge pclk);
      k++;
    end
    while (shear_down_out === 1'b1 && ld < 60000)
    begin
      @(posedge pclk);
      ld++;
    end
    k = 0;
    while (shear_up_out !== 1'b1 && k < 4)
    begin
      @(posedge pclk);
      k++;
    end
    while (shear_up_out === 1'b1 && lu < 60000)
    begin
      @(posedge pclk);
      lu++;
    end
    if (ld >= 60000 || lu >= 60000)
    begin
      fail_count++;
      summarize();
    end
  endtask
  task wait_cmd(input logic [31:0] v);
    k = 0;
    while (motor_cmd !== v && k < 60000)
    begin
      @(posedge pclk);
      k++;
    end
    chk(motor_cmd, v, "velocity");
  endtask
  // Each velocity step without material present must stay within the programmed acceleration.
  always @(posedge pclk)
  begin
    pcmd <= motor_cmd;
    if (presetn === 1'b1 && sheet_pin === 1'b0 && motor_cmd !== pcmd)
      chk(32'($signed(motor_cmd - pcmd) <= acc &&
        $signed(pcmd - motor_cmd) <= acc), 32'h1, "ramp");
  end
  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial
  begin
    {presetn, psel, penable, pwrite, paddr, pwdata, close_at} = '0;
    {fail_count, checks} = '0;
    seed = 30202;
    acc = 3;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd(REG_DWELL_DN, 32'h0000_007D, "down reset");
    rd(REG_DWELL_UP, 32'h0000_007D, "up reset");
    rd(REG_TRIM, 32'h4000_4000, "trim reset");
    apb(1'b0, 8'hFC, 32'h0000_0000);
    chk({31'h0000_0000, ev}, 32'h1, "unmapped error");
    chk(rv, 32'h0000_0000, "unmapped data");
    // Slow ramp toward jog speed while a plain stroke runs.
    apb(1'b1, REG_ACCEL, 32'h0000_0003);
    apb(1'b1, REG_VJOG, 32'h0000_0007);
    shot(1, 1, 32'h8, 0);
    chk(32'(ld inside {[1:20010]}), 32'h1, "down dwell");
    chk(32'(lu inside {[1:20010]}), 32'h1, "up dwell");
    wait_cmd(32'h0000_0007);
    // Switch cuts the down dwell; it stays made into the up dwell.
    acc = 65535;
    apb(1'b1, REG_ACCEL, 32'h0000_FFFF);
    apb(1'b1, REG_VMAX, 32'h0000_0009);
    shot(2, 2, 32'h4, 500);
    chk(32'(ld inside {[495:515]}), 32'h1, "switch override");
    chk(32'(lu inside {[19990:40010]}), 32'h1, "full up dwell");
    wait_cmd(32'h0000_0009);
    // Assist configured: no up dwell; out-of-range dwells clamp.
    shot(0, 10000, 32'h6, 0);
    chk(32'(ld inside {[1:20010]}), 32'h1, "min down");
    chk(32'(lu), 32'h0, "no up with assist");
    rd(REG_DWELL_DN, 32'h0000_0001, "down clamp");
    rd(REG_DWELL_UP, 32'h0000_270F, "up clamp");
    // Encoder tracking, single then two-encoder.
    m = ($random(seed) & 255) + 1;
    p = ($random(seed) & 255) + 1;
    n = ($random(seed) & 7) + 1;
    apb(1'b1, REG_MOTOR_RES, 32'(m));
    apb(1'b1, REG_LINE_RES, 32'(p));
    i_sdf_press.turn(1'b1, 3, 1'b0);
    i_sdf_press.turn(1'b0, n, 1'b0);
    apb(1'b0, REG_MPOS, 32'h0000_0000);
    chk(absv(rv), 32'(4 * n * m), "motor travel");
    i_sdf_press.turn(1'b0, n, 1'b1);
    rd(REG_MPOS, 32'h0000_0000, "motor back");
    apb(1'b1, REG_CTRL, 32'h0000_0005);
    i_sdf_press.set_sheet(1'b1);
    n = ($random(seed) & 7) + 1;
    i_sdf_press.turn(1'b1, n, 1'b0);
    apb(1'b0, REG_LENGTH, 32'h0000_0000);
    chk(absv(rv), 32'(4 * (3 + n) * p), "line length");
    rd(REG_CMD, 32'h0000_0009 + rv * 32'(GAIN_RST), "gain error");
    // Trim stays pending until confirmed.
    p = $random(seed) & 32'h0000_FFFF;
    apb(1'b1, REG_TRIM, 32'(p));
    rd(REG_TRIM, {p[15:0], 16'h4000}, "trim pending");
    apb(1'b1, REG_CTRL, 32'h0000_0025);
    rd(REG_TRIM, {p[15:0], p[15:0]}, "trim applied");
    summarize();
  end
endmodule
`default_nettype wire
